// File: core/thm_switch_map.sv
`timescale 1ns/100ps
`default_nettype none

module thm_switch_map #(
    parameter int STREAM_BITS  = 5,
    parameter int CHANNEL_BITS = 9,
    parameter int FO_COUNT     = 8
) (
    input  wire logic        i_clk,
    input  wire logic        i_reset,
    input  wire logic        i_cs,
    input  wire logic        i_we,
    input  wire logic [15:0] i_addr,
    input  wire logic [15:0] i_wdata,
    output logic      [15:0] o_rdata,
    output logic             o_rack,
    input  wire logic        i_output_drive_pin,
    input  wire logic [15:0] i_frame_align,
    output logic             o_frame_eval_start,
    output logic             o_fill_busy,
    input  wire logic        i_dm_we,
    input  wire logic [13:0] i_dm_addr,
    input  wire logic [7:0]  i_dm_data,
    input  wire logic        i_req_valid,
    output logic             o_req_ready,
    input  wire logic [4:0]  i_req_stream,
    input  wire logic [8:0]  i_req_channel,
    output logic             o_out_valid,
    input  wire logic        i_out_ready,
    output logic      [4:0]  o_tx_stream,
    output logic      [8:0]  o_tx_channel,
    output logic      [8:0]  o_tx_src_channel,
    output logic      [1:0]  o_tx_mode,
    output logic      [7:0]  o_tx_data,
    output logic             o_tx_oe,
    output logic             o_tx_ind,
    output logic      [10:0] o_tx_delay
);

    // ----------------------------------------
    // Elaboration checks
    // ----------------------------------------
    // Address split is fixed by the host map, so only these sizes fit
    if (STREAM_BITS != 5 || CHANNEL_BITS != 9 || FO_COUNT != 8) begin : g_bad_size
        $error("thm_switch_map: unsupported size parameters");
    end

    // ----------------------------------------
    // Delay arithmetic
    // ----------------------------------------
    function automatic logic [10:0] thm_delay(input logic [1:0] mode,
                                              input logic [8:0] n,
                                              input logic [8:0] m);
        logic [10:0] nn;
        logic [10:0] mm;
        nn = {2'h0, n};
        mm = {2'h0, m};
        if (mode == thm_pkg::MODE_CONST) begin
            return thm_pkg::FRAME_SLOTS + (thm_pkg::FRAME_SLOTS - nn) + mm;
        end
        if (mm <= nn + thm_pkg::VAR_GUARD) begin
            return thm_pkg::FRAME_SLOTS - (nn - mm);
        end
        return mm - nn;
    endfunction : thm_delay

    // ----------------------------------------
    // Storage and decode
    // ----------------------------------------
    logic [15:0]           conn_mem [0:16383];
    logic [7:0]            data_mem [0:16383];
    logic [15:0]           control_word;
    logic [15:0]           frame_offset [0:7];
    logic [15:0]           frame_alignment_result;
    thm_pkg::thm_fill_t    fill_state;
    logic [13:0]           fill_addr;
    logic                  srst;
    logic [1:0]            space;
    logic [13:0]           mem_index;
    logic                  wr;
    logic                  rd;
    logic                  is_cw;
    logic                  is_fa;
    logic                  is_fo;
    logic [2:0]            fo_idx;
    logic [15:0]           next_control;
    logic                  fill_start;

    assign srst      = control_word[thm_pkg::CW_SRST];
    assign space     = i_addr[15:14];
    assign mem_index = i_addr[13:0];
    assign wr        = i_cs && i_we;
    assign rd        = i_cs && !i_we;
    assign is_cw     = space == thm_pkg::SPACE_REG && i_addr[13:10] == thm_pkg::REG_CW;
    assign is_fa     = space == thm_pkg::SPACE_REG && i_addr[13:10] == thm_pkg::REG_FA;
    assign is_fo     = space == thm_pkg::SPACE_REG && i_addr[thm_pkg::FO_SEL_BIT];
    assign fo_idx    = i_addr[12:10];

    // Reserved bits never stored, so they always read back as zero
    assign next_control = i_wdata & thm_pkg::CW_WMASK;
    assign fill_start   = wr && is_cw && !srst && next_control[thm_pkg::CW_ARM]
                          && next_control[thm_pkg::CW_GO] && !control_word[thm_pkg::CW_GO];

    // ----------------------------------------
    // Control word
    // ----------------------------------------
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            control_word <= thm_pkg::CW_RESET;
        end else if (wr && is_cw && srst) begin
            // Only the reset bit itself may be written while held in reset
            control_word <= {next_control[thm_pkg::CW_SRST], 15'h0000};
        end else if (wr && is_cw) begin
            control_word <= next_control;
        end else if (fill_state == thm_pkg::THM_FILL_RUN && fill_addr == 14'h3fff) begin
            control_word <= control_word & thm_pkg::CW_FILL_CLR;
        end
    end

    assign o_frame_eval_start = control_word[thm_pkg::CW_FE];

    // ----------------------------------------
    // Frame offsets and alignment result
    // ----------------------------------------
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            for (int i = 0; i < 8; i++) begin
                frame_offset[i] <= thm_pkg::FO_RESET;
            end
        end else if (srst) begin
            for (int i = 0; i < 8; i++) begin
                frame_offset[i] <= thm_pkg::FO_RESET;
            end
        end else if (wr && is_fo) begin
            frame_offset[fo_idx] <= i_wdata;
        end
    end

    // Read-only: tracks the evaluator, host writes have no path here
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            frame_alignment_result <= thm_pkg::FO_RESET;
        end else begin
            frame_alignment_result <= i_frame_align;
        end
    end

    // ----------------------------------------
    // Block fill
    // ----------------------------------------
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            fill_state <= thm_pkg::THM_FILL_IDLE;
            fill_addr  <= 14'h0000;
        end else if (srst) begin
            fill_state <= thm_pkg::THM_FILL_IDLE;
            fill_addr  <= 14'h0000;
        end else begin
            case (fill_state)
                thm_pkg::THM_FILL_IDLE: begin
                    fill_addr <= 14'h0000;
                    if (fill_start) begin
                        fill_state <= thm_pkg::THM_FILL_RUN;
                    end
                end
                thm_pkg::THM_FILL_RUN: begin
                    fill_addr <= fill_addr + 14'h0001;
                    if (fill_addr == 14'h3fff) begin
                        fill_state <= thm_pkg::THM_FILL_IDLE;
                    end
                end
                default: begin
                    fill_state <= thm_pkg::THM_FILL_IDLE;
                end
            endcase
        end
    end

    assign o_fill_busy = fill_state == thm_pkg::THM_FILL_RUN;

    // ----------------------------------------
    // Memories
    // ----------------------------------------
    // Fill owns the write port; host entry writes during a fill are lost
    always_ff @(posedge i_clk) begin
        if (fill_state == thm_pkg::THM_FILL_RUN) begin
            conn_mem[fill_addr] <= {control_word[thm_pkg::CW_VAL_HI:thm_pkg::CW_VAL_LO], 14'h0000};
        end else if (wr && space == thm_pkg::SPACE_CM && !srst) begin
            conn_mem[mem_index] <= i_wdata;
        end
    end

    // Only the serial input side writes here; host writes are dropped
    always_ff @(posedge i_clk) begin
        if (i_dm_we) begin
            data_mem[i_dm_addr] <= i_dm_data;
        end
    end

    // ----------------------------------------
    // Host read port
    // ----------------------------------------
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            o_rdata <= 16'h0000;
            o_rack  <= 1'b0;
        end else begin
            o_rack <= rd;
            if (rd) begin
                if (space == thm_pkg::SPACE_DM) begin
                    o_rdata <= {8'h00, data_mem[mem_index]};
                end else if (space == thm_pkg::SPACE_CM) begin
                    o_rdata <= conn_mem[mem_index];
                end else if (is_fo) begin
                    o_rdata <= frame_offset[fo_idx];
                end else if (is_cw) begin
                    o_rdata <= control_word;
                end else if (is_fa) begin
                    o_rdata <= frame_alignment_result;
                end else begin
                    o_rdata <= 16'h0000;
                end
            end
        end
    end

    // ----------------------------------------
    // Output lookup pipeline
    // ----------------------------------------
    logic              accept;
    logic              ind_mode;
    logic              all_mode;
    logic              p1;
    logic              p2;
    logic [4:0]        s1_stream;
    logic [8:0]        s1_chan;
    logic              s1_ind;
    logic [15:0]       cm_q;
    logic [4:0]        s2_stream;
    logic [8:0]        s2_chan;
    logic              s2_ind;
    logic              s2_oe;
    logic              s2_pol;
    logic [15:0]       s2_entry;
    logic [7:0]        dm_q;
    logic [1:0]        s1_mode;
    logic              s1_oe;
    thm_pkg::thm_rec_t new_rec;

    assign accept   = i_req_valid && o_req_ready;
    assign all_mode = control_word[thm_pkg::CW_ALL];
    // All-pins indication wins over the half-pins form
    assign ind_mode = control_word[thm_pkg::CW_IND] && !all_mode;
    assign s1_mode  = cm_q[15:thm_pkg::CM_MODE_LO];
    assign s1_oe    = s1_mode != thm_pkg::MODE_HIZ
                      && (i_output_drive_pin || control_word[thm_pkg::CW_SB]);

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            p1 <= 1'b0;
            p2 <= 1'b0;
        end else if (srst) begin
            p1 <= 1'b0;
            p2 <= 1'b0;
        end else begin
            p1 <= accept;
            p2 <= p1;
        end
    end

    always_ff @(posedge i_clk) begin
        if (accept) begin
            s1_stream <= i_req_stream;
            s1_chan   <= i_req_channel;
            if (ind_mode && i_req_stream >= thm_pkg::IND_BASE) begin
                // Upper pin reports its partner stream
                s1_ind <= 1'b1;
                cm_q   <= conn_mem[{i_req_stream - thm_pkg::IND_BASE, i_req_channel}];
            end else begin
                s1_ind <= all_mode;
                cm_q   <= conn_mem[{i_req_stream, i_req_channel}];
            end
        end
        if (p1) begin
            s2_stream <= s1_stream;
            s2_chan   <= s1_chan;
            s2_ind    <= s1_ind;
            s2_oe     <= s1_oe;
            s2_pol    <= control_word[thm_pkg::CW_POL];
            s2_entry  <= cm_q;
            dm_q      <= data_mem[cm_q[13:0]];
        end
    end

    always_comb begin
        new_rec        = '0;
        new_rec.stream = s2_stream;
        new_rec.chan   = s2_chan;
        new_rec.src    = s2_entry[8:0];
        new_rec.mode   = s2_entry[15:thm_pkg::CM_MODE_LO];
        new_rec.delay  = thm_delay(new_rec.mode, s2_entry[8:0], s2_chan);
        new_rec.ind    = s2_ind;
        if (s2_ind) begin
            new_rec.oe   = 1'b1;
            new_rec.data = {8{s2_pol ? s2_oe : !s2_oe}};
        end else begin
            new_rec.oe   = s2_oe;
            new_rec.data = new_rec.mode == thm_pkg::MODE_PROC ? s2_entry[7:0] : dm_q;
        end
    end

    // ----------------------------------------
    // Two-entry output buffer
    // ----------------------------------------
    // Credit counts in-flight lookups so a stalled receiver drops nothing
    thm_pkg::thm_rec_t head;
    thm_pkg::thm_rec_t slot;
    logic [1:0]        cnt;
    logic [1:0]        next_cnt;
    logic              pop;

    assign pop      = o_out_valid && i_out_ready;
    assign next_cnt = cnt + {1'b0, p2} - {1'b0, pop};

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            cnt         <= 2'h0;
            o_out_valid <= 1'b0;
            o_req_ready <= 1'b0;
            head        <= '0;
            slot        <= '0;
        end else if (srst) begin
            cnt         <= 2'h0;
            o_out_valid <= 1'b0;
            o_req_ready <= 1'b0;
        end else begin
            cnt         <= next_cnt;
            o_out_valid <= next_cnt != 2'h0;
            o_req_ready <= ({1'b0, next_cnt} + {2'h0, accept} + {2'h0, p1}) < 3'h2;
            if (pop && cnt == 2'h2) begin
                head <= slot;
            end
            if (p2) begin
                if (cnt == 2'h0 || (cnt == 2'h1 && pop)) begin
                    head <= new_rec;
                end else begin
                    slot <= new_rec;
                end
            end
        end
    end

    assign o_tx_stream      = head.stream;
    assign o_tx_channel     = head.chan;
    assign o_tx_src_channel = head.src;
    assign o_tx_mode        = head.mode;
    assign o_tx_data        = head.data;
    assign o_tx_oe          = head.oe;
    assign o_tx_ind         = head.ind;
    assign o_tx_delay       = head.delay;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_reset);

    chk_hiz_mode: assert property (o_out_valid && !o_tx_ind && o_tx_mode == thm_pkg::MODE_HIZ |-> !o_tx_oe)
        else $error("channel in float mode drives");
    // Written out apart from the function so a slip in either one shows
    chk_var_delay: assert property (o_out_valid && o_tx_mode == thm_pkg::MODE_VAR
        |-> o_tx_delay == (({2'h0, o_tx_channel} <= {2'h0, o_tx_src_channel} + thm_pkg::VAR_GUARD)
            ? thm_pkg::FRAME_SLOTS - {2'h0, o_tx_src_channel} + {2'h0, o_tx_channel}
            : {2'h0, o_tx_channel} - {2'h0, o_tx_src_channel}))
        else $error("variable delay wrong");
    chk_const_delay: assert property (o_out_valid && o_tx_mode == thm_pkg::MODE_CONST
        |-> o_tx_delay == thm_pkg::FRAME_SLOTS + thm_pkg::FRAME_SLOTS
            - {2'h0, o_tx_src_channel} + {2'h0, o_tx_channel})
        else $error("constant delay wrong");
    chk_read_ack: assert property (i_cs && !i_we |=> o_rack && $past(i_cs))
        else $error("read not answered in one cycle");
    chk_cw_read: assert property (i_cs && !i_we && is_cw ##1 !$changed(control_word) |-> o_rdata == control_word)
        else $error("control read mismatch");
    chk_reserved_zero: assert property ((control_word & ~thm_pkg::CW_WMASK) == 16'h0000)
        else $error("reserved control bits set");
    chk_soft_reset: assert property (srst |=> frame_offset[0] == 16'h0000 && !o_out_valid && fill_state == thm_pkg::THM_FILL_IDLE)
        else $error("soft reset did not clear state");
    chk_fo_write: assert property (wr && is_fo && !srst |=> frame_offset[$past(fo_idx)] == $past(i_wdata))
        else $error("offset write lost");
    chk_ind_drive: assert property (o_out_valid && o_tx_ind |-> o_tx_oe)
        else $error("indication pin floats");
    chk_fill_clear: assert property (o_fill_busy ##1 !o_fill_busy && !srst
        |-> control_word[thm_pkg::CW_GO] == 1'b0 || $past(wr))
        else $error("fill end left go bit set");

    cov_fill_done: cover property (o_fill_busy ##1 !o_fill_busy);
    cov_ind_out: cover property (o_out_valid && o_tx_ind && i_out_ready);
    cov_var_wrap: cover property (o_out_valid && o_tx_mode == thm_pkg::MODE_VAR && o_tx_delay > 11'h1ff);
    cov_stall_full: cover property (cnt == 2'h2 && !i_out_ready);

endmodule : thm_switch_map

`default_nettype wire

// File: core/thm_pkg.sv
package thm_pkg;

    // ----------------------------------------
    // Address map
    // ----------------------------------------
    localparam logic [1:0]  SPACE_DM      = 2'h3;
    localparam logic [1:0]  SPACE_CM      = 2'h2;
    localparam logic [1:0]  SPACE_REG     = 2'h1;
    localparam logic [3:0]  REG_CW        = 4'h0;
    localparam logic [3:0]  REG_FA        = 4'h1;
    localparam int          FO_SEL_BIT    = 13;

    // ----------------------------------------
    // Control word layout
    // ----------------------------------------
    localparam int          CW_SRST       = 15;
    localparam int          CW_IND        = 14;
    localparam int          CW_POL        = 13;
    localparam int          CW_ALL        = 12;
    localparam int          CW_ARM        = 9;
    localparam int          CW_VAL_HI     = 8;
    localparam int          CW_VAL_LO     = 7;
    localparam int          CW_GO         = 6;
    localparam int          CW_SB         = 5;
    localparam int          CW_FE         = 4;
    localparam logic [15:0] CW_WMASK      = 16'hf3f0;
    localparam logic [15:0] CW_FILL_CLR   = 16'hfc3f;
    localparam logic [15:0] CW_RESET      = 16'h0000;
    localparam logic [15:0] FO_RESET      = 16'h0000;

    // ----------------------------------------
    // Connection entry layout and modes
    // ----------------------------------------
    localparam int          CM_MODE_LO    = 14;
    localparam logic [1:0]  MODE_VAR      = 2'h0;
    localparam logic [1:0]  MODE_CONST    = 2'h1;
    localparam logic [1:0]  MODE_PROC     = 2'h2;
    localparam logic [1:0]  MODE_HIZ      = 2'h3;
    localparam logic [10:0] FRAME_SLOTS   = 11'h200;
    localparam logic [10:0] VAR_GUARD     = 11'h002;
    localparam logic [4:0]  IND_BASE      = 5'h10;

    typedef enum logic {THM_FILL_IDLE, THM_FILL_RUN} thm_fill_t;

    typedef struct packed {
        logic [4:0]  stream;
        logic [8:0]  chan;
        logic [8:0]  src;
        logic [1:0]  mode;
        logic [7:0]  data;
        logic        oe;
        logic        ind;
        logic [10:0] delay;
    } thm_rec_t;

endpackage : thm_pkg

// File: sim/thm_host_model.sv
`timescale 1ns/100ps
`default_nettype none

module thm_host_model (
    input  wire logic        i_clk,
    input  wire logic [15:0] i_rdata,
    input  wire logic        i_rack,
    output logic             o_cs,
    output logic             o_we,
    output logic      [15:0] o_addr,
    output logic      [15:0] o_wdata
);
    initial begin
        o_cs    = 1'b0;
        o_we    = 1'b0;
        o_addr  = 16'h0000;
        o_wdata = 16'h0000;
    end

    // ----------------------------------------
    // One host cycle
    // ----------------------------------------
    // Idle bus shows the inverse so stale values never pass
    task automatic access(input logic w, input logic [15:0] a, input logic [15:0] d, output logic [15:0] q);
        @(posedge i_clk);
        o_cs    <= 1'b1;
        o_we    <= w;
        o_addr  <= a;
        o_wdata <= (a[15:10] == 6'h10) ? (d & thm_pkg::CW_WMASK) : d;
        @(posedge i_clk);
        o_cs    <= 1'b0;
        o_addr  <= ~a;
        o_wdata <= ~d;
        #1;
        q = (i_rack === 1'b1) ? i_rdata : 16'hxxxx;
    endtask : access

endmodule : thm_host_model
`default_nettype wire

// File: sim/test_tsi_host_map_and_output_control.sv
`timescale 1ns/100ps
`default_nettype none

module test_tsi_host_map_and_output_control;
    logic        i_clk = 1'b0;
    logic        i_reset = 1'b1;
    logic        i_cs, i_we, o_rack, o_frame_eval_start, o_fill_busy, o_req_ready, o_out_valid, o_tx_oe, o_tx_ind;
    logic        i_output_drive_pin = 1'b0, i_dm_we = 1'b0, i_req_valid = 1'b0, i_out_ready = 1'b1;
    logic [15:0] i_addr, i_wdata, o_rdata, q, i_frame_align = 16'h1234;
    logic [13:0] i_dm_addr = 14'h0000;
    logic [7:0]  i_dm_data = 8'h00, o_tx_data;
    logic [4:0]  i_req_stream = 5'h00, o_tx_stream;
    logic [8:0]  i_req_channel = 9'h000, o_tx_channel, o_tx_src_channel;
    logic [1:0]  o_tx_mode;
    logic [10:0] o_tx_delay;
    int          mismatches = 0;
    int          checks_done = 0;

    typedef struct packed {
        logic [15:0] entry;
        logic [8:0]  ch;
        logic        pin;
        logic [10:0] delay;
        logic        oe;
        logic [7:0]  data;
    } thm_row_t;
    // Source channel 10 of stream 1 holds 5a; output on stream 3
    thm_row_t rows [6] = '{'{16'h020a, 9'd12, 1'b1, 11'd514, 1'b1, 8'h5a},
                           '{16'h020a, 9'd13, 1'b1, 11'd3, 1'b1, 8'h5a},
                           '{16'h020a, 9'd10, 1'b1, 11'd512, 1'b1, 8'h5a},
                           '{16'h420a, 9'd5, 1'b0, 11'd1019, 1'b0, 8'h5a},
                           '{16'h80a7, 9'd7, 1'b1, 11'd0, 1'b1, 8'ha7},
                           '{16'hc20a, 9'd8, 1'b1, 11'd0, 1'b0, 8'h00}};

    always #2.5 i_clk = ~i_clk;

    thm_switch_map uut (.i_clk, .i_reset, .i_cs, .i_we, .i_addr, .i_wdata, .o_rdata, .o_rack,
        .i_output_drive_pin, .i_frame_align, .o_frame_eval_start, .o_fill_busy, .i_dm_we, .i_dm_addr,
        .i_dm_data, .i_req_valid, .o_req_ready, .i_req_stream, .i_req_channel, .o_out_valid, .i_out_ready,
        .o_tx_stream, .o_tx_channel, .o_tx_src_channel, .o_tx_mode, .o_tx_data, .o_tx_oe, .o_tx_ind, .o_tx_delay);
    thm_host_model host (.i_clk(i_clk), .i_rdata(o_rdata), .i_rack(o_rack), .o_cs(i_cs), .o_we(i_we),
        .o_addr(i_addr), .o_wdata(i_wdata));

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        host.access(1'b1, a, d, q);
    endtask : wr

    task automatic rd(input logic [15:0] a, input logic [15:0] exp);
        host.access(1'b0, a, 16'h0000, q);
        chk(q, exp);
    endtask : rd

    task automatic send(input logic [4:0] s, input logic [8:0] c, input logic p);
        @(posedge i_clk);
        i_req_valid <= 1'b1;
        i_req_stream <= s;
        i_req_channel <= c;
        i_output_drive_pin <= p;
        @(negedge i_clk);
        while (o_req_ready !== 1'b1) @(negedge i_clk);
        @(posedge i_clk);
        i_req_valid <= 1'b0;
        i_req_stream <= ~s;
        i_req_channel <= ~c;
    endtask : send

    task automatic get_rec;
        @(negedge i_clk);
        for (int n = 0; n < 20 && o_out_valid !== 1'b1; n++) @(negedge i_clk);
        chk(16'(o_out_valid), 16'h0001);
    endtask : get_rec

    task automatic lookup(input logic [4:0] s, input logic [8:0] c, input logic p);
        send(s, c, p);
        get_rec;
    endtask : lookup

    task automatic final_report;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : final_report

    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial begin
        thm_row_t r;
        repeat (2) @(posedge i_clk);
        i_reset <= 1'b0;
        @(posedge i_clk);
        i_dm_we <= 1'b1;
        i_dm_addr <= 14'h020a;
        i_dm_data <= 8'h5a;
        @(posedge i_clk);
        i_dm_we <= 1'b0;
        foreach (rows[i]) begin
            r = rows[i];
            wr({2'b10, 5'd3, r.ch}, r.entry);
            lookup(5'd3, r.ch, r.pin);
            chk(16'({o_tx_stream, o_tx_channel}), {2'b00, 5'd3, r.ch});
            chk(16'({o_tx_mode, o_tx_src_channel}), 16'({r.entry[15:14], r.entry[8:0]}));
            if (!r.entry[15]) chk(16'(o_tx_delay), 16'(r.delay));
            chk(16'({o_tx_ind, o_tx_oe}), 16'(r.oe));
            if (r.entry[15:14] != 2'h3) chk(16'(o_tx_data), 16'(r.data));
        end
        $display("test modes done");
        rd(16'h4000, 16'h0000);
        rd(16'h47ff, 16'h1234);
        wr(16'h4400, 16'hffff);
        rd(16'h4400, 16'h1234);
        rd(16'h4800, 16'h0000);
        wr(16'hc20a, 16'h00ff);
        rd(16'hc20a, 16'h005a);
        for (int k = 0; k < 8; k++) begin
            rd({3'b011, 3'(k), 10'h000}, 16'h0000);
            wr({3'b011, 3'(k), 10'h3ff}, 16'h0a00 + 16'(k));
        end
        for (int k = 0; k < 8; k++) rd({3'b011, 3'(k), 10'h155}, 16'h0a00 + 16'(k));
        wr(16'h4000, 16'h0010);
        @(negedge i_clk);
        chk(16'(o_frame_eval_start), 16'h0001);
        $display("test registers done");
        wr(16'h4000, 16'h0020);
        wr({2'b10, 5'd19, 9'd12}, 16'hc000);
        lookup(5'd3, 9'd12, 1'b0);
        chk(16'(o_tx_oe), 16'h0001);
        lookup(5'd19, 9'd12, 1'b0);
        chk(16'({o_tx_ind, o_tx_oe}), 16'h0000);
        wr(16'h4000, 16'h6020);
        lookup(5'd19, 9'd12, 1'b0);
        chk(16'({o_tx_ind, o_tx_data}), 16'h01ff);
        wr(16'h4000, 16'h4020);
        lookup(5'd19, 9'd12, 1'b0);
        chk(16'({o_tx_ind, o_tx_data}), 16'h0100);
        $display("test indication done");
        wr(16'h4000, 16'h0020);
        @(posedge i_clk);
        i_out_ready <= 1'b0;
        send(5'd3, 9'd13, 1'b0);
        send(5'd3, 9'd12, 1'b0);
        repeat (6) @(negedge i_clk);
        chk(16'({o_req_ready, o_out_valid}), 16'h0001);
        @(posedge i_clk);
        i_out_ready <= 1'b1;
        get_rec;
        chk(16'(o_tx_delay), 16'd3);
        get_rec;
        chk(16'(o_tx_delay), 16'd514);
        $display("test buffer done");
        wr(16'h4000, 16'h8000);
        // Ready is a register: it drops one edge after the reset bit lands
        repeat (2) @(negedge i_clk);
        chk(16'(o_req_ready), 16'h0000);
        wr(16'h6000, 16'h5555);
        rd(16'h6000, 16'h0000);
        wr(16'h4000, 16'h0000);
        rd(16'h4000, 16'h0000);
        wr(16'h4000, 16'h0340);
        @(negedge i_clk);
        chk(16'(o_fill_busy), 16'h0001);
        for (int n = 0; n < 20000 && o_fill_busy !== 1'b0; n++) @(negedge i_clk);
        rd(16'h4000, 16'h0000);
        rd({2'b10, 5'd3, 9'd12}, 16'h8000);
        $display("test reset and fill done");
        wr(16'h4000, 16'h0020);
        @(posedge i_clk);
        i_reset <= 1'b1;
        @(posedge i_clk);
        i_reset <= 1'b0;
        rd(16'h4000, 16'h0000);
        $display("test hard reset done");
        final_report;
    end

    initial begin
        #200000;
        mismatches++;
        final_report;
    end

endmodule : test_tsi_host_map_and_output_control
`default_nettype wire
